// ==== src/mcc_pkg.sv ====
`default_nettype none
package mcc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CONV_W = 17;
    localparam int RES_W = 16;
    localparam int NUM_CHAN = 6;
    localparam int CHAN_IDX_W = 3;
    localparam int LED_W = 3;

    localparam logic [ADDR_W-1:0] OFS_CHAN_LIST = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_LED_SEL_A = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_LED_SEL_B = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_PROX_ALIGN = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_AMB_ALIGN = 8'h06;
    localparam logic [ADDR_W-1:0] OFS_RESULT_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_RESULT_LAST = 8'h2b;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h31;

    localparam logic [DATA_W-1:0] RST_CHAN_LIST = 8'h00;
    localparam logic [DATA_W-1:0] RST_LED_SEL_A = 8'h21;
    localparam logic [DATA_W-1:0] RST_LED_SEL_B = 8'h00;
    localparam logic [DATA_W-1:0] RST_PROX_ALIGN = 8'h00;
    localparam logic [DATA_W-1:0] RST_AMB_ALIGN = 8'h00;

    // Writable bits of each register; the rest read as zero
    localparam logic [DATA_W-1:0] MASK_CHAN_LIST = 8'h77;
    localparam logic [DATA_W-1:0] MASK_LED_SEL_A = 8'h77;
    localparam logic [DATA_W-1:0] MASK_LED_SEL_B = 8'h07;
    localparam logic [DATA_W-1:0] MASK_PROX_ALIGN = 8'h70;
    localparam logic [DATA_W-1:0] MASK_AMB_ALIGN = 8'h30;

    // Field positions
    localparam int LED_A_LO = 0;
    localparam int LED_B_LO = 4;
    localparam int LED_C_LO = 0;
    localparam int PROX_A_ALIGN_BIT = 4;
    localparam int PROX_B_ALIGN_BIT = 5;
    localparam int PROX_C_ALIGN_BIT = 6;
    localparam int AMB_IR_ALIGN_BIT = 4;
    localparam int AMB_VIS_ALIGN_BIT = 5;
    localparam int CTRL_FORCE_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LIST_ERR_BIT = 1;
    localparam int STAT_AUTO_BIT = 2;

    // Measurement slots in sweep order
    localparam logic [CHAN_IDX_W-1:0] CH_PROX_A = 3'h0;
    localparam logic [CHAN_IDX_W-1:0] CH_PROX_B = 3'h1;
    localparam logic [CHAN_IDX_W-1:0] CH_PROX_C = 3'h2;
    localparam logic [CHAN_IDX_W-1:0] CH_AMB_VIS = 3'h3;
    localparam logic [CHAN_IDX_W-1:0] CH_AMB_IR = 3'h4;
    localparam logic [CHAN_IDX_W-1:0] CH_AUX = 3'h5;
    localparam logic [CHAN_IDX_W-1:0] CH_END = 3'h6;

    // Channel list bit for each slot
    localparam int LIST_BIT_PROX_A = 0;
    localparam int LIST_BIT_PROX_B = 1;
    localparam int LIST_BIT_PROX_C = 2;
    localparam int LIST_BIT_AMB_VIS = 4;
    localparam int LIST_BIT_AMB_IR = 5;
    localparam int LIST_BIT_AUX = 6;

    typedef enum logic [1:0] {
        MCC_IDLE = 2'b00,
        MCC_SCAN = 2'b01,
        MCC_CONV = 2'b11,
        MCC_STORE = 2'b10
    } mcc_state_t;
endpackage
`default_nettype wire

// ==== src/mcc_top.sv ====
// Notes on behaviour
// RULE1: Enabled proximity channels measured, results stored per channel.
// RULE2: Host writes non-zero channel list before starting.
// RULE3: Second proximity measurement drives LEDs from bits 6:4.
// RULE4: First proximity uses bits 2:0, reset 0x21.
// RULE5: Third proximity uses second select bits 2:0.
// RULE6: Field bit 0 LED1, bit 1 LED2.
// RULE7: Field bit 2 drives LED3.
// RULE8: Third proximity alignment bit 6 selects low bits.
// RULE9: Second proximity alignment bit 5 selects low bits.
// RULE10: First proximity alignment bit 4, reset zero.
// RULE11: Ambient bit 5 selects low bits, visible measurement.
// RULE12: Ambient bit 4 selects low bits, infrared measurement.
// RULE13: List bits 4,5,6 enable visible, infrared, auxiliary.
// RULE14: Host writes zero to reserved bits.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mcc_top
    import mcc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_W-1:0] RD_DATA_O,
    output logic CONV_REQ_O,
    output logic [CHAN_IDX_W-1:0] CONV_SEL_O,
    input wire logic CONV_DONE_I,
    input wire logic [CONV_W-1:0] CONV_DATA_I,
    output logic [LED_W-1:0] LED_DRIVE_O,
    output logic SWEEP_DONE_O
);

    logic [DATA_W-1:0] chan_list_reg;
    logic [DATA_W-1:0] led_sel_a_reg;
    logic [DATA_W-1:0] led_sel_b_reg;
    logic [DATA_W-1:0] prox_align_reg;
    logic [DATA_W-1:0] amb_align_reg;
    logic [RES_W-1:0] result_reg [NUM_CHAN];
    logic auto_reg;
    logic list_err_reg;
    mcc_state_t state_reg;
    mcc_state_t state_next;
    logic [CHAN_IDX_W-1:0] idx_reg;
    logic [CHAN_IDX_W-1:0] idx_next;

    logic wr_list;
    logic wr_ctrl;
    logic start_req;
    logic list_empty;
    logic cur_enabled;
    logic sweep_end;
    logic conv_start;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] control_word;

    function automatic logic chan_enabled(input logic [DATA_W-1:0] list, input logic [CHAN_IDX_W-1:0] idx);
        case (idx)
            CH_PROX_A: chan_enabled = list[LIST_BIT_PROX_A]; // RULE1
            CH_PROX_B: chan_enabled = list[LIST_BIT_PROX_B]; // RULE1
            CH_PROX_C: chan_enabled = list[LIST_BIT_PROX_C]; // RULE1
            CH_AMB_VIS: chan_enabled = list[LIST_BIT_AMB_VIS]; // RULE13
            CH_AMB_IR: chan_enabled = list[LIST_BIT_AMB_IR]; // RULE13
            CH_AUX: chan_enabled = list[LIST_BIT_AUX]; // RULE13
            default: chan_enabled = 1'b0;
        endcase
    endfunction

    function automatic logic [LED_W-1:0] led_mask(input logic [CHAN_IDX_W-1:0] idx);
        // Each field bit maps one-to-one onto a driver pin
        case (idx)
            CH_PROX_A: led_mask = led_sel_a_reg[LED_A_LO +: LED_W]; // RULE4 RULE6 RULE7
            CH_PROX_B: led_mask = led_sel_a_reg[LED_B_LO +: LED_W]; // RULE3 RULE6 RULE7
            CH_PROX_C: led_mask = led_sel_b_reg[LED_C_LO +: LED_W]; // RULE5 RULE6 RULE7
            default: led_mask = '0;
        endcase
    endfunction

    function automatic logic low_bits_sel(input logic [CHAN_IDX_W-1:0] idx);
        case (idx)
            CH_PROX_A: low_bits_sel = prox_align_reg[PROX_A_ALIGN_BIT]; // RULE10
            CH_PROX_B: low_bits_sel = prox_align_reg[PROX_B_ALIGN_BIT]; // RULE9
            CH_PROX_C: low_bits_sel = prox_align_reg[PROX_C_ALIGN_BIT]; // RULE8
            CH_AMB_VIS: low_bits_sel = amb_align_reg[AMB_VIS_ALIGN_BIT]; // RULE11
            CH_AMB_IR: low_bits_sel = amb_align_reg[AMB_IR_ALIGN_BIT]; // RULE12
            // Auxiliary inputs have no alignment control; keep the low word
            default: low_bits_sel = 1'b1;
        endcase
    endfunction

    assign wr_list = WR_I && (ADDR_I == OFS_CHAN_LIST);
    assign wr_ctrl = WR_I && (ADDR_I == OFS_CONTROL);
    assign start_req = wr_ctrl && (WR_DATA_I[CTRL_FORCE_BIT] || WR_DATA_I[CTRL_AUTO_BIT]);
    // An empty list would sweep forever without converting anything
    assign list_empty = ((chan_list_reg & MASK_CHAN_LIST) == '0); // RULE2
    assign cur_enabled = chan_enabled(chan_list_reg, idx_reg);
    assign sweep_end = (state_reg == MCC_SCAN) && (idx_reg == CH_END);
    // Entry into conversion decides both the request pulse and the slot latch
    assign conv_start = (state_reg == MCC_SCAN) && (state_next == MCC_CONV);

    // Status and control read images; bit positions come from the package
    always_comb
    begin
        status_word = '0;
        control_word = '0;
        status_word[STAT_BUSY_BIT] = (state_reg != MCC_IDLE);
        status_word[STAT_LIST_ERR_BIT] = list_err_reg; // RULE2
        status_word[STAT_AUTO_BIT] = auto_reg;
        control_word[CTRL_AUTO_BIT] = auto_reg;
    end

    // Configuration registers; reserved bits are never stored
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            chan_list_reg <= RST_CHAN_LIST;
            led_sel_a_reg <= RST_LED_SEL_A; // RULE4
            led_sel_b_reg <= RST_LED_SEL_B;
            prox_align_reg <= RST_PROX_ALIGN; // RULE10
            amb_align_reg <= RST_AMB_ALIGN;
        end
        else if (WR_I)
        begin
            case (ADDR_I)
                OFS_CHAN_LIST: chan_list_reg <= WR_DATA_I & MASK_CHAN_LIST;
                OFS_LED_SEL_A: led_sel_a_reg <= WR_DATA_I & MASK_LED_SEL_A;
                OFS_LED_SEL_B: led_sel_b_reg <= WR_DATA_I & MASK_LED_SEL_B;
                OFS_PROX_ALIGN: prox_align_reg <= WR_DATA_I & MASK_PROX_ALIGN;
                OFS_AMB_ALIGN: amb_align_reg <= WR_DATA_I & MASK_AMB_ALIGN;
                default: ;
            endcase
        end
    end

    // Autonomous mode: set by control write, refused with an empty list
    // Dropping the list mid-run stops repetition at the end of the sweep
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            auto_reg <= 1'b0;
        else if (wr_ctrl)
            auto_reg <= WR_DATA_I[CTRL_AUTO_BIT] && !list_empty; // RULE2
        else if (list_empty)
            auto_reg <= 1'b0;
    end

    // Error flag: set by a refused start, cleared by a later control or channel list write; set wins
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            list_err_reg <= 1'b0;
        else if (start_req && list_empty)
            list_err_reg <= 1'b1; // RULE2
        else if (wr_ctrl || wr_list)
            list_err_reg <= 1'b0;
    end

    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        case (state_reg)
            MCC_IDLE:
            begin
                idx_next = CH_PROX_A;
                if (start_req && !list_empty)
                    state_next = MCC_SCAN; // RULE2
            end
            MCC_SCAN:
            begin
                if (idx_reg == CH_END)
                begin
                    idx_next = CH_PROX_A;
                    if (!(auto_reg && !list_empty))
                        state_next = MCC_IDLE;
                end
                else if (cur_enabled)
                    state_next = MCC_CONV; // RULE1 RULE13
                else
                    idx_next = idx_reg + 3'h1;
            end
            MCC_CONV:
            begin
                if (CONV_DONE_I)
                    state_next = MCC_STORE;
            end
            MCC_STORE:
            begin
                state_next = MCC_SCAN;
                idx_next = idx_reg + 3'h1;
            end
            default:
            begin
                state_next = MCC_IDLE;
                idx_next = CH_PROX_A;
            end
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            state_reg <= MCC_IDLE;
            idx_reg <= CH_PROX_A;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
        end
    end

    // Converter handshake: one-cycle request on entry to conversion
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            CONV_REQ_O <= 1'b0;
            CONV_SEL_O <= CH_PROX_A;
        end
        else
        begin
            CONV_REQ_O <= conv_start;
            if (conv_start)
                CONV_SEL_O <= idx_reg;
        end
    end

    // LEDs stay lit for the whole proximity conversion, dark otherwise
    // A select write mid-conversion changes the drive at once; update between sweeps
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            LED_DRIVE_O <= '0;
        else if (state_next == MCC_CONV)
            LED_DRIVE_O <= led_mask(idx_next); // RULE3 RULE4 RULE5
        else
            LED_DRIVE_O <= '0;
    end

    // Result capture with per-channel word alignment
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            for (int i = 0; i < NUM_CHAN; i++)
                result_reg[i] <= '0;
        end
        else if ((state_reg == MCC_CONV) && CONV_DONE_I)
        begin
            if (low_bits_sel(idx_reg))
                result_reg[idx_reg] <= CONV_DATA_I[RES_W-1:0]; // RULE8 RULE9 RULE10 RULE11 RULE12
            else
                result_reg[idx_reg] <= CONV_DATA_I[CONV_W-1:CONV_W-RES_W]; // RULE8 RULE9 RULE10 RULE11 RULE12
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            SWEEP_DONE_O <= 1'b0;
        else
            SWEEP_DONE_O <= sweep_end;
    end

    // Read port: data appear the cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_I)
    begin
        logic [ADDR_W-1:0] rel;
        rel = ADDR_I - OFS_RESULT_BASE;
        if (SYS_RST_I)
            RD_DATA_O <= '0;
        else if (!RD_I)
            RD_DATA_O <= '0;
        else if ((ADDR_I >= OFS_RESULT_BASE) && (ADDR_I <= OFS_RESULT_LAST))
        begin
            // Low byte at the even offset, high byte at the odd one
            if (rel[0])
                RD_DATA_O <= result_reg[rel[CHAN_IDX_W:1]][RES_W-1:DATA_W]; // RULE1
            else
                RD_DATA_O <= result_reg[rel[CHAN_IDX_W:1]][DATA_W-1:0]; // RULE1
        end
        else
        begin
            case (ADDR_I)
                OFS_CHAN_LIST: RD_DATA_O <= chan_list_reg;
                OFS_LED_SEL_A: RD_DATA_O <= led_sel_a_reg;
                OFS_LED_SEL_B: RD_DATA_O <= led_sel_b_reg;
                OFS_PROX_ALIGN: RD_DATA_O <= prox_align_reg;
                OFS_AMB_ALIGN: RD_DATA_O <= amb_align_reg;
                OFS_CONTROL: RD_DATA_O <= control_word;
                OFS_STATUS: RD_DATA_O <= status_word;
                default: RD_DATA_O <= '0;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== tb/mcc_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcc_conv_model
    import mcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conv_req_i,
    input wire logic [CHAN_IDX_W-1:0] sel_i,
    input wire logic [CONV_W-1:0] seed_i,
    input wire logic [3:0] dly_i,
    output logic done_o,
    output logic [CONV_W-1:0] data_o
);
    logic busy_reg;
    logic [3:0] cnt_reg;
    logic [CHAN_IDX_W-1:0] sel_reg;
    logic [CONV_W-1:0] noise_reg;
    // Data lines wander outside the done pulse so a stale capture shows up
    always_ff @(posedge clk_i)
    begin
        noise_reg <= noise_reg + 17'h0b5a3;
        done_o <= 1'b0;
        if (rst_i)
        begin
            busy_reg <= 1'b0;
            noise_reg <= 17'h00000;
        end
        else if (conv_req_i)
        begin
            busy_reg <= 1'b1;
            cnt_reg <= dly_i;
            sel_reg <= sel_i;
        end
        else if (busy_reg && cnt_reg == 4'h0)
        begin
            done_o <= 1'b1;
            busy_reg <= 1'b0;
        end
        else if (busy_reg)
        begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
    assign data_o = done_o ? seed_i + 17'(sel_reg) * 17'h01357 : noise_reg;
endmodule
`default_nettype wire

// ==== tb/mcc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcc_chk
    import mcc_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DATA_W-1:0] RD_DATA_O,
    input wire logic CONV_REQ_O,
    input wire logic [CHAN_IDX_W-1:0] CONV_SEL_O,
    input wire logic CONV_DONE_I,
    input wire logic [LED_W-1:0] LED_DRIVE_O,
    input wire logic SWEEP_DONE_O
);
    logic [7:0] led_a_reg;
    logic [7:0] led_b_reg;
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            led_a_reg <= RST_LED_SEL_A;
            led_b_reg <= RST_LED_SEL_B;
        end
        else if (WR_I && ADDR_I == OFS_LED_SEL_A)
            led_a_reg <= WR_DATA_I & MASK_LED_SEL_A;
        else if (WR_I && ADDR_I == OFS_LED_SEL_B)
            led_b_reg <= WR_DATA_I & MASK_LED_SEL_B;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_req(logic [2:0] s);
        CONV_REQ_O && CONV_SEL_O == s;
    endsequence
    led_first_a: assert property (s_req(CH_PROX_A) |-> LED_DRIVE_O == led_a_reg[2:0])
        else $error("LED mask wrong in first proximity slot");
    led_second_a: assert property (s_req(CH_PROX_B) |-> LED_DRIVE_O == led_a_reg[6:4])
        else $error("LED mask wrong in second proximity slot");
    led_third_a: assert property (s_req(CH_PROX_C) |-> LED_DRIVE_O == led_b_reg[2:0])
        else $error("LED mask wrong in third proximity slot");
    ambient_dark_a: assert property (CONV_REQ_O && CONV_SEL_O > CH_PROX_C |-> LED_DRIVE_O == 3'h0)
        else $error("LED driven in a non-proximity slot");
    req_pulse_a: assert property (CONV_REQ_O |=> !CONV_REQ_O)
        else $error("converter start longer than one cycle");
    led_hold_a: assert property (LED_DRIVE_O != 3'h0 && !CONV_DONE_I |=> $stable(LED_DRIVE_O))
        else $error("LED drive changed during conversion");
    led_release_a: assert property (LED_DRIVE_O != 3'h0 && CONV_DONE_I |=> LED_DRIVE_O == 3'h0)
        else $error("LED drive not released after done");
    led_read_a: assert property (RD_I && ADDR_I == OFS_LED_SEL_A |=> RD_DATA_O == led_a_reg)
        else $error("LED select read back wrong");
    sweep_pulse_a: assert property (SWEEP_DONE_O |=> !SWEEP_DONE_O)
        else $error("sweep done longer than one cycle");
endmodule
`default_nettype wire

// ==== tb/mcc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcc_top_test;
    import mcc_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, req, done, swdone;
    logic [7:0] addr = 0, wdata = 0, rdata, got;
    logic [2:0] sel, led;
    logic [16:0] cdata, seed = 0;
    logic [3:0] dly = 0;
    logic [31:0] xs_state = 91;
    logic [7:0] pa, am, list, wv;
    logic [15:0] ev;
    int fails = 0, total_checks = 0, k, s, i;
    logic [7:0] ra[6] = '{OFS_CHAN_LIST, OFS_LED_SEL_A, OFS_LED_SEL_B, OFS_PROX_ALIGN, OFS_AMB_ALIGN, 8'h04};
    logic [7:0] rv[6] = '{RST_CHAN_LIST, RST_LED_SEL_A, RST_LED_SEL_B, RST_PROX_ALIGN, RST_AMB_ALIGN, 8'h00};
    logic [7:0] rm[6] = '{MASK_CHAN_LIST, MASK_LED_SEL_A, MASK_LED_SEL_B, MASK_PROX_ALIGN, MASK_AMB_ALIGN, 8'h00};
    always #2 clk = ~clk;
    mcc_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RD_DATA_O(rdata), .CONV_REQ_O(req), .CONV_SEL_O(sel), .CONV_DONE_I(done), .CONV_DATA_I(cdata),
        .LED_DRIVE_O(led), .SWEEP_DONE_O(swdone));
    mcc_conv_model CONV (.clk_i(clk), .rst_i(rst), .conv_req_i(req), .sel_i(sel), .seed_i(seed),
        .dly_i(dly), .done_o(done), .data_o(cdata));
    function automatic logic [31:0] xs();
        xs_state ^= xs_state << 13;
        xs_state ^= xs_state >> 17;
        xs_state ^= xs_state << 5;
        return xs_state;
    endfunction
    function automatic logic [15:0] exp_res(int sl);
        logic [16:0] v;
        logic al;
        v = seed + 17'(sl) * 17'h01357;
        al = (sl == 5) ? 1'b1 : (sl < 3) ? pa[4+sl] : am[8-sl];
        return al ? v[15:0] : v[16:1];
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wait_sweep();
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 500 && !seen; n++)
        begin
            @(negedge clk);
            seen = (swdone === 1'b1);
        end
        if (!seen)
        begin
            fails++;
            end_of_test();
        end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            rd_reg(ra[i], got);
            check("reset value", got, rv[i]);
        end
        for (i = 0; i < 6; i++)
        begin
            wv = 8'(xs());
            // Reserved bits stay zero on mapped registers; the unmapped offset takes any value
            if (i < 5)
                wv = wv & rm[i];
            wr_reg(ra[i], wv);
            rd_reg(ra[i], got);
            check("register readback", got, wv & rm[i]);
        end
        for (k = 0; k < 6; k++)
        begin
            pa = 8'(xs()) & MASK_PROX_ALIGN;
            am = 8'(xs()) & MASK_AMB_ALIGN;
            list = (k == 0) ? MASK_CHAN_LIST : (8'(xs()) & MASK_CHAN_LIST) | 8'h01;
            seed <= 17'(xs());
            dly <= 4'(xs());
            wr_reg(OFS_LED_SEL_A, 8'(xs()) & MASK_LED_SEL_A);
            wr_reg(OFS_LED_SEL_B, 8'(xs()) & MASK_LED_SEL_B);
            wr_reg(OFS_PROX_ALIGN, pa);
            wr_reg(OFS_AMB_ALIGN, am);
            wr_reg(OFS_CHAN_LIST, list);
            wr_reg(OFS_CONTROL, 8'h01);
            wait_sweep();
            for (s = 0; s < 6; s++)
            begin
                if (list[s < 3 ? s : s + 1])
                begin
                    ev = exp_res(s);
                    rd_reg(OFS_RESULT_BASE + 8'(2 * s), got);
                    check("result low byte", got, ev[7:0]);
                    rd_reg(OFS_RESULT_BASE + 8'(2 * s + 1), got);
                    check("result high byte", got, ev[15:8]);
                end
            end
        end
        wr_reg(OFS_CHAN_LIST, 8'h01);
        wr_reg(OFS_CONTROL, 8'h02);
        wait_sweep();
        wait_sweep();
        rd_reg(OFS_STATUS, got);
        check("auto status", got, 8'h05);
        rd_reg(OFS_CONTROL, got);
        check("auto control", got, 8'h02);
        wr_reg(OFS_CONTROL, 8'h00);
        repeat (80) @(posedge clk);
        rd_reg(OFS_STATUS, got);
        check("auto stopped", got, 8'h00);
        ev = exp_res(0);
        rd_reg(OFS_RESULT_BASE, got);
        check("auto result low byte", got, ev[7:0]);
        wr_reg(OFS_CHAN_LIST, 8'h00);
        wr_reg(OFS_CONTROL, 8'h03);
        rd_reg(OFS_STATUS, got);
        check("empty list status", got, 8'h02);
        end_of_test();
    end
endmodule
bind mcc_top mcc_chk CHK (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O), .CONV_REQ_O(CONV_REQ_O), .CONV_SEL_O(CONV_SEL_O),
    .CONV_DONE_I(CONV_DONE_I), .LED_DRIVE_O(LED_DRIVE_O), .SWEEP_DONE_O(SWEEP_DONE_O));
`default_nettype wire
